// file: include/cssc_pkg.sv
// Constants shared by the configurable stage and stepper control block.
// Assumes a single 20 MHz system clock and synchronous command frames.
package cssc_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int unsigned HOLD_MIN_MS = 400;
  localparam int unsigned HOLD_MAX_MS = 800;
  localparam int unsigned HOLD_CYCLES = HOLD_MIN_MS * CYCLES_PER_MS;
  localparam int unsigned HOLD_MAX_CYCLES = HOLD_MAX_MS * CYCLES_PER_MS;

  // ==========================================================================
  // Stage positions in the eight-bit stage vector
  localparam int unsigned STAGE_COUNT = 8;
  localparam int unsigned ST_B1_HS_A = 0;
  localparam int unsigned ST_B1_LS_A = 1;
  localparam int unsigned ST_B1_HS_B = 2;
  localparam int unsigned ST_B1_LS_B = 3;
  localparam int unsigned ST_B2_HS_A = 4;
  localparam int unsigned ST_B2_HS_B = 5;
  localparam int unsigned ST_B2_LS_A = 6;
  localparam int unsigned ST_B2_LS_B = 7;

  // ==========================================================================
  // Arrangement select codes and reset values
  localparam logic [1:0] ARR_BRIDGE = 2'h0;
  localparam logic [1:0] ARR_RESET = 2'h0;
  localparam logic [1:0] PHASE_START = 2'h0;
  localparam logic [1:0] PHASE_STEP = 2'h1;
  localparam logic [7:0] STAGES_OFF = 8'h00;
  localparam logic DIR_RESET = 1'b1;

  // ==========================================================================
  // Phase drive patterns, bit order as the stage vector
  localparam logic [7:0] PHASE0_DRIVE = 8'h69;
  localparam logic [7:0] PHASE1_DRIVE = 8'h99;
  localparam logic [7:0] PHASE2_DRIVE = 8'h96;
  localparam logic [7:0] PHASE3_DRIVE = 8'h66;

  // ==========================================================================
  // Low-battery hold sequencer states
  typedef enum logic [2:0] {
    HOLD_IDLE = 3'h1,
    HOLD_RUN = 3'h2,
    HOLD_DONE = 3'h4
  } cssc_hold_state_type;

endpackage : cssc_pkg

// file: src/cssc_hold_timer.sv
// Low-battery hold of one high-side stage during cranking.
// Assumes start and takeover are single-cycle pulses synchronous to clk_sys.
module cssc_hold_timer #(
  parameter int unsigned HOLD_CYCLES = cssc_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic takeover,
  // Status
  output logic hold_on
);

  localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);

  initial begin
    if (HOLD_CYCLES < 1) begin
      $error("HOLD_CYCLES must be at least one");
    end
  end

  cssc_pkg::cssc_hold_state_type state_q;
  logic [CW-1:0] cnt_q;

  // ==========================================================================
  // Hold sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= cssc_pkg::HOLD_IDLE;
      cnt_q <= '0;
      hold_on <= 1'b0;
    end else begin
      case (state_q)
        cssc_pkg::HOLD_IDLE: begin
          if (start) begin
            state_q <= cssc_pkg::HOLD_RUN; // R4
            cnt_q <= CW'(HOLD_CYCLES - 1);
            hold_on <= 1'b1;
          end
        end
        cssc_pkg::HOLD_RUN: begin
          if (takeover || cnt_q == '0) begin
            state_q <= cssc_pkg::HOLD_DONE; // R17
            hold_on <= 1'b0;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        cssc_pkg::HOLD_DONE: begin
          state_q <= cssc_pkg::HOLD_IDLE;
        end
        default: begin
          state_q <= cssc_pkg::HOLD_IDLE;
          hold_on <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Checks
  hold_bound_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
    hold_on |-> cnt_q <= CW'(HOLD_CYCLES - 1))
    else $error("hold counter out of range");
  hold_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (start && state_q == cssc_pkg::HOLD_IDLE) |=> hold_on)
    else $error("hold did not start");

endmodule : cssc_hold_timer

// file: src/cssc_stage_ctrl.sv
// Eight configurable power stages: individual switches or two stepper bridges.
// Assumes command frames arrive as synchronous one-cycle strobes with write flags.
//
// Notes on behaviour
// R1: Four high and four low stages; bridge arrangement after reset.
// R2: Individual mode may parallel each bridge's two low-side stages.
// R3: Individual mode drives each stage from its own bit, unchecked.
// R4: Held high stages stay on from controller reset fall until timeout or takeover.
// R5: Two separate bits enable hold on each held high stage.
// R6: Any hold enable set forces individual arrangement.
// R7: Bridge mode forms two full bridges driven only by enable, direction, step.
// R8: With enable set, a step write from 0 to 1 advances one phase.
// R9: A step write of 0 keeps the conducting switches unchanged.
// R10: Enable at 0 turns off every bridge switch.
// R11: Direction 1 walks the phase table forward.
// R12: Direction 0 walks the phase table backward.
// R13: After reset the phase is the start position.
// R14: Bridge mode never turns on high and low of one half-bridge.
// R15: Step and direction in one frame step with the old direction.
// R16: Step and enable in one frame: only enable is taken.
// R17: Hold interval lasts between 400 and 800 ms.
// R18: Two-bit phase index wraps; rising step found against stored step bit.
module cssc_stage_ctrl #(
  parameter int unsigned HOLD_CYCLES = cssc_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Command frame strobe
  input wire logic frame_valid,
  // Stepper bits of a frame
  input wire logic frame_en_wr,
  input wire logic frame_en,
  input wire logic frame_dir_wr,
  input wire logic frame_dir,
  input wire logic frame_step_wr,
  input wire logic frame_step,
  // Individual stage bits of a frame
  input wire logic frame_sw_wr,
  input wire logic [7:0] frame_sw,
  // Configuration bits of a frame
  input wire logic frame_cfg_wr,
  input wire logic [1:0] frame_stage_arrangement_sel,
  input wire logic frame_hold_enable_bridge1_high,
  input wire logic frame_hold_enable_bridge2_high,
  input wire logic frame_pair_ls_b1,
  input wire logic frame_pair_ls_b2,
  // Supply and controller state
  input wire logic low_batt_level,
  input wire logic mcu_reset_n,
  // Stage drives
  output logic b1_hs_a,
  output logic b1_ls_a,
  output logic b1_hs_b,
  output logic b1_ls_b,
  output logic b2_hs_a,
  output logic b2_hs_b,
  output logic b2_ls_a,
  output logic b2_ls_b,
  // Status
  output logic bridge_mode,
  output logic [1:0] phase_index
);

  initial begin
    if (HOLD_CYCLES < 1) begin
      $error("HOLD_CYCLES must be positive");
    end
  end

  // ==========================================================================
  // Phase decode
  function automatic logic [7:0] phase_drive(input logic [1:0] idx);
    logic [7:0] drv;
    drv = cssc_pkg::PHASE0_DRIVE;
    case (idx)
      2'h0: drv = cssc_pkg::PHASE0_DRIVE;
      2'h1: drv = cssc_pkg::PHASE1_DRIVE;
      2'h2: drv = cssc_pkg::PHASE2_DRIVE;
      default: drv = cssc_pkg::PHASE3_DRIVE;
    endcase
    return drv;
  endfunction : phase_drive

  function automatic logic [7:0] no_cross(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[cssc_pkg::ST_B1_HS_A] && v[cssc_pkg::ST_B1_LS_A]) begin
      r[cssc_pkg::ST_B1_HS_A] = 1'b0;
      r[cssc_pkg::ST_B1_LS_A] = 1'b0;
    end
    if (v[cssc_pkg::ST_B1_HS_B] && v[cssc_pkg::ST_B1_LS_B]) begin
      r[cssc_pkg::ST_B1_HS_B] = 1'b0;
      r[cssc_pkg::ST_B1_LS_B] = 1'b0;
    end
    if (v[cssc_pkg::ST_B2_HS_A] && v[cssc_pkg::ST_B2_LS_A]) begin
      r[cssc_pkg::ST_B2_HS_A] = 1'b0;
      r[cssc_pkg::ST_B2_LS_A] = 1'b0;
    end
    if (v[cssc_pkg::ST_B2_HS_B] && v[cssc_pkg::ST_B2_LS_B]) begin
      r[cssc_pkg::ST_B2_HS_B] = 1'b0;
      r[cssc_pkg::ST_B2_LS_B] = 1'b0;
    end
    return r;
  endfunction : no_cross

  function automatic logic crossed(input logic [7:0] v);
    return (v[cssc_pkg::ST_B1_HS_A] && v[cssc_pkg::ST_B1_LS_A])
        || (v[cssc_pkg::ST_B1_HS_B] && v[cssc_pkg::ST_B1_LS_B])
        || (v[cssc_pkg::ST_B2_HS_A] && v[cssc_pkg::ST_B2_LS_A])
        || (v[cssc_pkg::ST_B2_HS_B] && v[cssc_pkg::ST_B2_LS_B]);
  endfunction : crossed

  // ==========================================================================
  // State
  logic [1:0] arr_sel_q;
  logic hold_en1_q;
  logic hold_en2_q;
  logic pair1_q;
  logic pair2_q;
  logic en_q;
  logic dir_q;
  logic step_q;
  logic [1:0] phase_q;
  logic [7:0] sw_q;
  logic mcu_rst_prev_q;
  logic [7:0] stage_q;
  logic [7:0] stage_d;
  logic indiv_mode;
  logic step_rise;
  logic mcu_rst_fall;
  logic hold1_on;
  logic hold2_on;
  logic sw_take;

  assign indiv_mode = (arr_sel_q != cssc_pkg::ARR_BRIDGE) || hold_en1_q || hold_en2_q; // R6
  assign step_rise = frame_valid && frame_step_wr && frame_step && !step_q // R18
      && en_q && !frame_en_wr; // R16
  assign mcu_rst_fall = mcu_rst_prev_q && !mcu_reset_n;
  assign sw_take = frame_valid && frame_sw_wr;

  // ==========================================================================
  // Configuration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      arr_sel_q <= cssc_pkg::ARR_RESET; // R1
      hold_en1_q <= 1'b0;
      hold_en2_q <= 1'b0;
      pair1_q <= 1'b0;
      pair2_q <= 1'b0;
    end else if (frame_valid && frame_cfg_wr) begin
      arr_sel_q <= frame_stage_arrangement_sel;
      hold_en1_q <= frame_hold_enable_bridge1_high; // R5
      hold_en2_q <= frame_hold_enable_bridge2_high; // R5
      pair1_q <= frame_pair_ls_b1;
      pair2_q <= frame_pair_ls_b2;
    end
  end

  // ==========================================================================
  // Stepper command bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b0;
      dir_q <= cssc_pkg::DIR_RESET;
      step_q <= 1'b0;
    end else if (frame_valid) begin
      if (frame_en_wr) begin
        en_q <= frame_en;
      end
      if (frame_dir_wr) begin
        dir_q <= frame_dir;
      end
      if (frame_step_wr && !frame_en_wr) begin
        step_q <= frame_step; // R16
      end
    end
  end

  // ==========================================================================
  // Phase index
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= cssc_pkg::PHASE_START; // R13
    end else if (step_rise) begin // R8 R9
      if (dir_q) begin
        phase_q <= phase_q + cssc_pkg::PHASE_STEP; // R11 R15
      end else begin
        phase_q <= phase_q - cssc_pkg::PHASE_STEP; // R12 R15
      end
    end
  end

  // ==========================================================================
  // Individual stage bits
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sw_q <= cssc_pkg::STAGES_OFF;
      mcu_rst_prev_q <= 1'b1;
    end else begin
      mcu_rst_prev_q <= mcu_reset_n;
      if (mcu_rst_fall) begin
        sw_q <= cssc_pkg::STAGES_OFF;
      end else if (sw_take) begin
        sw_q <= frame_sw;
      end
    end
  end

  // ==========================================================================
  // Low-battery hold of the two high-side a stages
  cssc_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(mcu_rst_fall && low_batt_level && hold_en1_q && stage_q[cssc_pkg::ST_B1_HS_A]), // R4
    .takeover(sw_take),
    .hold_on(hold1_on)
  );

  cssc_hold_timer #(
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_hold2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(mcu_rst_fall && low_batt_level && hold_en2_q && stage_q[cssc_pkg::ST_B2_HS_A]), // R4
    .takeover(sw_take),
    .hold_on(hold2_on)
  );

  // ==========================================================================
  // Stage drive selection
  always_comb begin
    stage_d = cssc_pkg::STAGES_OFF;
    if (indiv_mode) begin
      stage_d = sw_q; // R3
      if (pair1_q) begin
        stage_d[cssc_pkg::ST_B1_LS_B] = sw_q[cssc_pkg::ST_B1_LS_A]; // R2
      end
      if (pair2_q) begin
        stage_d[cssc_pkg::ST_B2_LS_B] = sw_q[cssc_pkg::ST_B2_LS_A]; // R2
      end
      if (hold1_on) begin
        stage_d[cssc_pkg::ST_B1_HS_A] = 1'b1; // R4
      end
      if (hold2_on) begin
        stage_d[cssc_pkg::ST_B2_HS_A] = 1'b1; // R4
      end
    end else if (en_q) begin
      stage_d = no_cross(phase_drive(phase_q)); // R7 R14
    end else begin
      stage_d = cssc_pkg::STAGES_OFF; // R10
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= cssc_pkg::STAGES_OFF;
      bridge_mode <= 1'b1;
      phase_index <= cssc_pkg::PHASE_START;
    end else begin
      stage_q <= stage_d;
      bridge_mode <= !indiv_mode;
      phase_index <= phase_q;
    end
  end

  assign b1_hs_a = stage_q[cssc_pkg::ST_B1_HS_A];
  assign b1_ls_a = stage_q[cssc_pkg::ST_B1_LS_A];
  assign b1_hs_b = stage_q[cssc_pkg::ST_B1_HS_B];
  assign b1_ls_b = stage_q[cssc_pkg::ST_B1_LS_B];
  assign b2_hs_a = stage_q[cssc_pkg::ST_B2_HS_A];
  assign b2_hs_b = stage_q[cssc_pkg::ST_B2_HS_B];
  assign b2_ls_a = stage_q[cssc_pkg::ST_B2_LS_A];
  assign b2_ls_b = stage_q[cssc_pkg::ST_B2_LS_B];

  // ==========================================================================
  // Checks
  reset_bridge_a: assert property (@(posedge clk_sys) // R1
    $rose(rst_n) |-> !indiv_mode)
    else $error("arrangement not bridge after reset");

  hold_forces_indiv_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
    (hold_en1_q || hold_en2_q) |=> !bridge_mode)
    else $error("hold enable did not force individual mode");

  indiv_direct_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R3
    (indiv_mode && !pair1_q && !pair2_q && !hold1_on && !hold2_on) |=> stage_q == $past(sw_q))
    else $error("individual stage not following its bit");

  pair_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R2
    (indiv_mode && pair1_q) |=> stage_q[cssc_pkg::ST_B1_LS_B] == stage_q[cssc_pkg::ST_B1_LS_A])
    else $error("paired low side not following");

  enable_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R10
    (!indiv_mode && !en_q) |=> stage_q == cssc_pkg::STAGES_OFF)
    else $error("bridge not off with enable clear");

  no_shoot_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
    bridge_mode |-> !crossed(stage_q))
    else $error("half-bridge cross conduction");

  step_fwd_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
    (step_rise && dir_q) |=> phase_q == $past(phase_q) + 2'h1)
    else $error("forward step wrong");

  step_rev_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
    (step_rise && !dir_q) |=> phase_q == $past(phase_q) - 2'h1)
    else $error("reverse step wrong");

  step_zero_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
    (frame_valid && frame_step_wr && !frame_step) |=> $stable(phase_q))
    else $error("phase moved on a zero step write");

  step_with_en_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
    (frame_valid && frame_en_wr) |=> $stable(phase_q))
    else $error("step taken with enable in same frame");

  step_old_dir_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
    (step_rise && frame_dir_wr) |=> phase_q == ($past(dir_q) ? $past(phase_q) + 2'h1 : $past(phase_q) - 2'h1))
    else $error("step used new direction");

  phase_out_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
    (!indiv_mode && en_q && !step_rise) ##1 (!indiv_mode && en_q)
      |-> stage_q == phase_drive(phase_q))
    else $error("bridge drive does not match phase");

  start_phase_a: assert property (@(posedge clk_sys) // R13
    $rose(rst_n) |-> phase_q == cssc_pkg::PHASE_START)
    else $error("phase not at start after reset");

  held_on_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
    (hold1_on && indiv_mode) |=> b1_hs_a)
    else $error("held stage dropped during hold");

endmodule : cssc_stage_ctrl

// file: sim/cssc_mcu_model.sv
// Engine controller model: issues command frames to the stage control block.
// Assumes the block takes a frame on the rising clk_sys edge while frame_valid is high.
module cssc_mcu_model (
  // Clock
  input wire logic clk_sys,
  // Frame strobe and write flags
  output logic frame_valid,
  output logic frame_en_wr,
  output logic frame_dir_wr,
  output logic frame_step_wr,
  output logic frame_sw_wr,
  output logic frame_cfg_wr,
  // Frame data
  output logic frame_en,
  output logic frame_dir,
  output logic frame_step,
  output logic [7:0] frame_sw,
  output logic [1:0] frame_stage_arrangement_sel,
  output logic frame_hold_enable_bridge1_high,
  output logic frame_hold_enable_bridge2_high,
  output logic frame_pair_ls_b1,
  output logic frame_pair_ls_b2
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Frame tasks
  // Data outside a frame has no meaning: show the inverse of the last value
  task automatic idle();
    frame_valid = 1'b0;
    {frame_en_wr, frame_dir_wr, frame_step_wr, frame_sw_wr, frame_cfg_wr} = 5'h00;
    {frame_en, frame_dir, frame_step, frame_sw} = ~{frame_en, frame_dir, frame_step, frame_sw};
    {frame_stage_arrangement_sel, frame_hold_enable_bridge1_high, frame_hold_enable_bridge2_high,
      frame_pair_ls_b1, frame_pair_ls_b2} = ~{frame_stage_arrangement_sel, frame_hold_enable_bridge1_high,
      frame_hold_enable_bridge2_high, frame_pair_ls_b1, frame_pair_ls_b2};
  endtask : idle

  // Flags {en, dir, step, sw, cfg}; v is {en, dir, step}; cfg is {sel, hold1, hold2, pair1, pair2}
  task automatic send(input logic [4:0] wr, input logic [2:0] v, input logic [7:0] sw, input logic [5:0] cfg);
    @(negedge clk_sys);
    {frame_en_wr, frame_dir_wr, frame_step_wr, frame_sw_wr, frame_cfg_wr} = wr;
    {frame_en, frame_dir, frame_step} = v;
    frame_sw = sw;
    {frame_stage_arrangement_sel, frame_hold_enable_bridge1_high, frame_hold_enable_bridge2_high,
      frame_pair_ls_b1, frame_pair_ls_b2} = cfg;
    frame_valid = 1'b1;
    @(negedge clk_sys);
    idle();
  endtask : send

  // Step bit travels in a frame of its own in this task
  task automatic step_write(input logic s);
    send(5'h04, {2'h0, s}, 8'h00, 6'h00);
  endtask : step_write

  initial begin
    {frame_en, frame_dir, frame_step, frame_sw} = 11'h000;
    {frame_stage_arrangement_sel, frame_hold_enable_bridge1_high, frame_hold_enable_bridge2_high,
      frame_pair_ls_b1, frame_pair_ls_b2} = 6'h00;
    idle();
  end
endmodule : cssc_mcu_model

// file: sim/tb_top.sv
// Self-checking bench for the configurable stage and stepper control block.
// Assumes the controller model drives all frames; supply and controller reset come from here.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  localparam int unsigned HOLD = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic low_batt_level = 1'b0;
  logic mcu_reset_n = 1'b1;
  logic bm_was = 1'b0;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] fwd [4] = '{8'h69, 8'h99, 8'h96, 8'h66};
  wire frame_valid, frame_en_wr, frame_dir_wr, frame_step_wr, frame_sw_wr, frame_cfg_wr;
  wire frame_en, frame_dir, frame_step, frame_pair_ls_b1, frame_pair_ls_b2;
  wire frame_hold_enable_bridge1_high, frame_hold_enable_bridge2_high;
  wire [7:0] frame_sw;
  wire [1:0] frame_stage_arrangement_sel;
  wire b1_hs_a, b1_ls_a, b1_hs_b, b1_ls_b, b2_hs_a, b2_hs_b, b2_ls_a, b2_ls_b;
  wire [7:0] st;
  wire bm;
  wire [1:0] idx;

  always #25 clk_sys = ~clk_sys;

  // ==========================================================================
  // Instances
  cssc_mcu_model mcu (.clk_sys, .frame_valid, .frame_en_wr, .frame_dir_wr, .frame_step_wr, .frame_sw_wr,
    .frame_cfg_wr, .frame_en, .frame_dir, .frame_step, .frame_sw, .frame_stage_arrangement_sel,
    .frame_hold_enable_bridge1_high, .frame_hold_enable_bridge2_high, .frame_pair_ls_b1, .frame_pair_ls_b2);

  cssc_stage_ctrl #(.HOLD_CYCLES(HOLD)) dut (.clk_sys, .rst_n, .frame_valid, .frame_en_wr, .frame_en,
    .frame_dir_wr, .frame_dir, .frame_step_wr, .frame_step, .frame_sw_wr, .frame_sw, .frame_cfg_wr,
    .frame_stage_arrangement_sel, .frame_hold_enable_bridge1_high, .frame_hold_enable_bridge2_high,
    .frame_pair_ls_b1, .frame_pair_ls_b2, .low_batt_level, .mcu_reset_n,
    .b1_hs_a, .b1_ls_a, .b1_hs_b, .b1_ls_b, .b2_hs_a, .b2_hs_b, .b2_ls_a, .b2_ls_b,
    .bridge_mode(bm), .phase_index(idx));

  assign st = {b2_ls_b, b2_ls_a, b2_hs_b, b2_hs_a, b1_ls_b, b1_hs_b, b1_ls_a, b1_hs_a};

  // ==========================================================================
  // Compare and helper tasks
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic chk2(input string what, input logic [1:0] exp, input logic [1:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk2

  task automatic chk1(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic wt(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : wt

  task automatic at(input logic [1:0] i);
    chk8("stages", fwd[i], st);
    chk2("phase", i, idx);
  endtask : at

  task automatic en_w(input logic e);
    mcu.send(5'h10, {e, 2'h0}, 8'h00, 6'h00);
    wt(3);
  endtask : en_w

  task automatic sw_w(input logic [7:0] s);
    mcu.send(5'h02, 3'h0, s, 6'h00);
    wt(3);
  endtask : sw_w

  task automatic cfg_w(input logic [5:0] c);
    mcu.send(5'h01, 3'h0, 8'h00, c);
    wt(3);
  endtask : cfg_w

  task automatic step();
    mcu.step_write(1'b1);
    mcu.step_write(1'b0);
    wt(3);
  endtask : step

  // Shoot-through watch while bridge mode has stood for a cycle
  always @(negedge clk_sys) begin
    if (bm === 1'b1 && bm_was && ((st[0] & st[1]) | (st[2] & st[3]) | (st[4] & st[6]) | (st[5] & st[7]))) begin
      num_errors++;
      $display("unexpected half-bridge drive: expected no overlap, seen %h", st);
    end
    bm_was = (bm === 1'b1);
  end

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk8("stages", 8'h00, st);
    chk1("mode", 1'b1, bm);
    chk2("phase", 2'h0, idx);
    $display("test reset done");
  endtask : t_reset

  task automatic t_forward();
    en_w(1'b1);
    at(2'h0);
    mcu.step_write(1'b1);
    wt(3);
    at(2'h1);
    mcu.step_write(1'b1);
    wt(3);
    at(2'h1);
    mcu.step_write(1'b0);
    wt(3);
    at(2'h1);
    for (int i = 2; i <= 4; i++) begin
      step();
      at(i[1:0]);
    end
    $display("test forward done");
  endtask : t_forward

  task automatic t_reverse();
    mcu.send(5'h08, 3'h0, 8'h00, 6'h00);
    wt(3);
    at(2'h0);
    for (int i = 1; i <= 4; i++) begin
      step();
      at(2'h0 - i[1:0]);
    end
    $display("test reverse done");
  endtask : t_reverse

  task automatic t_same_frame();
    mcu.send(5'h0C, 3'h3, 8'h00, 6'h00);
    wt(3);
    at(2'h3);
    mcu.step_write(1'b0);
    step();
    at(2'h0);
    en_w(1'b0);
    mcu.send(5'h14, 3'h5, 8'h00, 6'h00);
    wt(3);
    at(2'h0);
    mcu.step_write(1'b1);
    wt(3);
    at(2'h1);
    mcu.step_write(1'b0);
    $display("test same frame done");
  endtask : t_same_frame

  task automatic t_disable();
    en_w(1'b0);
    chk8("stages", 8'h00, st);
    step();
    chk8("stages", 8'h00, st);
    chk2("phase", 2'h1, idx);
    en_w(1'b1);
    at(2'h1);
    en_w(1'b0);
    $display("test disable done");
  endtask : t_disable

  task automatic t_individual();
    for (int a = 1; a < 4; a++) begin
      cfg_w({a[1:0], 4'h0});
      chk1("mode", 1'b0, bm);
      sw_w(8'(8'h33 << a));
      chk8("stages", 8'(8'h33 << a), st);
    end
    cfg_w({2'h2, 4'h3});
    sw_w(8'h42);
    chk8("stages", 8'hCA, st);
    sw_w(8'h00);
    cfg_w(6'h00);
    chk1("mode", 1'b1, bm);
    chk8("stages", 8'h00, st);
    $display("test individual done");
  endtask : t_individual

  task automatic t_hold();
    cfg_w({2'h0, 4'h8});
    chk1("mode", 1'b0, bm);
    sw_w(8'h11);
    low_batt_level = 1'b1;
    mcu_reset_n = 1'b0;
    wt(5);
    chk8("stages", 8'h01, st);
    wt(HOLD - 8);
    chk8("stages", 8'h01, st);
    wt(HOLD + 3);
    chk8("stages", 8'h00, st);
    mcu_reset_n = 1'b1;
    cfg_w({2'h0, 4'hC});
    sw_w(8'h11);
    mcu_reset_n = 1'b0;
    wt(5);
    chk8("stages", 8'h11, st);
    mcu_reset_n = 1'b1;
    sw_w(8'h10);
    chk8("stages", 8'h10, st);
    low_batt_level = 1'b0;
    sw_w(8'h11);
    mcu_reset_n = 1'b0;
    wt(5);
    chk8("stages", 8'h00, st);
    mcu_reset_n = 1'b1;
    $display("test hold done");
  endtask : t_hold

  task automatic t_mid_reset();
    cfg_w(6'h00);
    en_w(1'b1);
    step();
    at(2'h2);
    rst_n = 1'b0;
    wt(2);
    chk8("stages", 8'h00, st);
    rst_n = 1'b1;
    wt(1);
    chk1("mode", 1'b1, bm);
    chk2("phase", 2'h0, idx);
    en_w(1'b1);
    at(2'h0);
    $display("test mid reset done");
  endtask : t_mid_reset

  // ==========================================================================
  // Run control
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    stop_test();
  end

  initial begin
    repeat (5) @(negedge clk_sys);
    rst_n = 1'b1;
    t_reset();
    t_forward();
    t_reverse();
    t_same_frame();
    t_disable();
    t_individual();
    t_hold();
    t_mid_reset();
    stop_test();
  end
endmodule : tb_top
